// >>> src/nvc_pkg.sv
// Constants, register map and carrier types of the nonvolatile access controller.
// Assumes a 100 MHz core clock and byte-wide special function register access.
package nvc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map (byte registers, index on the plain register port)
  localparam int         REG_ADDR_W    = 4;
  localparam logic [3:0] OFS_ADDR_LOW  = 4'h0;
  localparam logic [3:0] OFS_ADDR_HIGH = 4'h1;
  localparam logic [3:0] OFS_DATA_LOW  = 4'h2;
  localparam logic [3:0] OFS_DATA_HIGH = 4'h3;
  localparam logic [3:0] OFS_CONTROL   = 4'h4;
  localparam logic [3:0] OFS_UNLOCK    = 4'h5;
  localparam logic [3:0] OFS_FLAGS2    = 4'h6;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int CTL_RD_BIT     = 0;
  localparam int CTL_WR_BIT     = 1;
  localparam int CTL_PERMIT_BIT = 2;
  localparam int CTL_ABORT_BIT  = 3;
  localparam int CTL_LATCH_BIT  = 5;
  localparam int CTL_SPACE_BIT  = 7;
  localparam int FLG_DONE_BIT   = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Memory geometry
  localparam int EE_DEPTH    = 256;
  localparam int PM_DEPTH    = 32768;
  localparam int PM_ADDR_W   = 15;
  localparam int PM_DATA_W   = 14;
  localparam int ADDR_HIGH_W = 7;
  localparam int DATA_HIGH_W = 6;
  localparam int LATCH_WORDS = 32;
  localparam int LATCH_IDX_W = 5;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and keys
  localparam logic [7:0] RESET_BYTE       = 8'h00;
  localparam logic [7:0] ERASED_BYTE      = 8'hff;
  localparam logic [7:0] UNLOCK_KEY_FIRST = 8'h55;
  localparam logic [7:0] UNLOCK_KEY_LAST  = 8'haa;

  ////////////////////////////////////////////////////////////////////////////
  // Self-program lock encodings and protected bounds
  localparam logic [1:0]  LOCK_NONE  = 2'h3;
  localparam logic [1:0]  LOCK_LOW   = 2'h2;
  localparam logic [1:0]  LOCK_HALF  = 2'h1;
  localparam logic [14:0] BOUND_LOW  = 15'h0200;
  localparam logic [14:0] BOUND_HALF = 15'h1000;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_PERIOD_NS      = 10;
  localparam int WRITE_TIME_MS      = 2;
  localparam int WRITE_TIME_CYCLES  = WRITE_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int TIMER_W            = 18;
  localparam logic [1:0] SETUP_CYCLES = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } nvc_bus_req_type;

  typedef struct packed {
    logic space_select;
    logic latch_only_load;
    logic commit_permit;
    logic wr_trig;
    logic rd_trig;
  } nvc_ctrl_type;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETUP,
    ST_PROGRAM,
    ST_COMMIT,
    ST_FINISH
  } nvc_state_type;

endpackage

// >>> src/nvc_access_ctrl.sv
// Data EEPROM and program memory self-access controller with its register file.
// Assumes a single 100 MHz clock, a register port driven from that clock, and
// a separate power-on reset that outlives the ordinary device reset.
//
// Overview of operation
// - Data EEPROM holds 256 bytes, addressed by the low address register only.
// - Low data register carries the EEPROM byte read or written.
// - Program accesses use a 14-bit data pair and a 15-bit address pair.
// - Address pair reaches 32K program words, high byte in high register.
// - An EEPROM byte write erases the location, then programs it.
// - Write duration comes from an internal timer, not software.
// - Self-program lock decides writable program blocks; program reads always allowed.
// - Code protection blocks the external programmer, not processor accesses.
// - Space select: clear means EEPROM, set means program memory; reset clears.
// - Read and write triggers are set-only; hardware clears them on completion.
// - Writes proceed only with write permit set; permit clears at power-up.
// - Abort flag sets when reset interrupts a write; survives that reset.
// - Done flag sets when an EEPROM write or a program memory commit completes; software clears it.
// - Unlock register always reads as zero.
// - Two setup cycles follow the write trigger before the write runs.
// - Processor halts only during the programming cycle, for about 2 ms.
// - With latch-only load set, a program memory write loads latches without halting.
// - Execution resumes at the third instruction after the trigger.
`timescale 1ns/1ns

module nvc_access_ctrl
  import nvc_pkg::*;
#(
  parameter int WRITE_CYCLES = nvc_pkg::WRITE_TIME_CYCLES
)
(
  input  wire logic                     clock,
  input  wire logic                     rst_n,
  input  wire logic                     por_n,
  input  wire nvc_pkg::nvc_bus_req_type bus_req,
  output logic [7:0]                    rdata,
  input  wire logic [1:0]               self_program_lock,
  input  wire logic                     code_protect,
  output logic                          cpu_halt,
  output logic                          programmer_deny
);
  import nvc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Storage and state
  logic [7:0]              ee_mem [EE_DEPTH];
  logic [PM_DATA_W-1:0]    pm_mem [PM_DEPTH];
  logic [PM_DATA_W-1:0]    latch_word [LATCH_WORDS];
  logic [LATCH_WORDS-1:0]  latch_valid;
  logic [7:0]              nv_addr_low;
  logic [ADDR_HIGH_W-1:0]  nv_addr_high;
  logic [7:0]              nv_data_low;
  logic [DATA_HIGH_W-1:0]  nv_data_high;
  nvc_ctrl_type            ctrl;
  logic                    nv_done_flag;
  logic                    commit_abort_flag;
  logic [1:0]              unlock_step;
  nvc_state_type           state;
  logic [TIMER_W-1:0]      timer;
  logic [1:0]              setup_count;
  logic [LATCH_IDX_W-1:0]  commit_idx;
  logic                    set_done;
  logic                    busy_por;
  logic [2:0]              rst_sample;

  ////////////////////////////////////////////////////////////////////////////
  // Decodes
  logic                    wr_ctrl;
  logic                    write_accept;
  logic                    read_accept;
  logic [PM_ADDR_W-1:0]    pm_addr;
  logic [PM_DATA_W-1:0]    pm_wdata;
  logic [LATCH_IDX_W-1:0]  latch_idx;
  logic                    pm_locked;
  logic                    timer_done;
  logic                    start_write;
  logic                    end_write;

  function automatic logic write_protected(input logic [1:0] lock,
                                           input logic [PM_ADDR_W-1:0] addr);
    if (lock == LOCK_NONE)
      write_protected = 1'b0;
    else if (lock == LOCK_LOW)
      write_protected = (addr < BOUND_LOW);
    else if (lock == LOCK_HALF)
      write_protected = (addr < BOUND_HALF);
    else
      write_protected = 1'b1;
  endfunction

  function automatic logic reg_hit(input nvc_bus_req_type req, input logic [3:0] ofs);
    reg_hit = (req.addr == ofs);
  endfunction

  assign pm_addr      = {nv_addr_high, nv_addr_low};
  assign pm_wdata     = {nv_data_high, nv_data_low};
  assign latch_idx    = pm_addr[LATCH_IDX_W-1:0];
  assign pm_locked    = write_protected(self_program_lock, pm_addr);
  assign wr_ctrl      = bus_req.wr && reg_hit(bus_req, OFS_CONTROL);
  // The key must be the write just before the trigger, with permit already set
  assign write_accept = wr_ctrl && bus_req.wdata[CTL_WR_BIT] && !ctrl.wr_trig
                        && ctrl.commit_permit && (unlock_step == 2'h2)
                        && (state == ST_IDLE);
  assign read_accept  = wr_ctrl && bus_req.wdata[CTL_RD_BIT] && !ctrl.rd_trig
                        && !ctrl.wr_trig && (state == ST_IDLE);
  assign timer_done   = (timer == TIMER_W'(WRITE_CYCLES - 1));
  assign start_write  = (state == ST_SETUP) && (setup_count == SETUP_CYCLES - 2'h1);
  assign end_write    = (state == ST_FINISH);

  ////////////////////////////////////////////////////////////////////////////
  // Address and data registers; read completion loads the low data register, or the pair for program reads
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      nv_addr_low  <= RESET_BYTE;
      nv_addr_high <= '0;
      nv_data_low  <= RESET_BYTE;
      nv_data_high <= '0;
    end
    else if (ctrl.rd_trig)
    begin
      if (!ctrl.space_select)
        nv_data_low <= ee_mem[nv_addr_low];
      else
      begin
        nv_data_low  <= pm_mem[pm_addr][7:0];
        nv_data_high <= pm_mem[pm_addr][PM_DATA_W-1:8];
      end
    end
    else if (bus_req.wr)
    begin
      if (reg_hit(bus_req, OFS_ADDR_LOW))
        nv_addr_low <= bus_req.wdata;
      else if (reg_hit(bus_req, OFS_ADDR_HIGH))
        nv_addr_high <= bus_req.wdata[ADDR_HIGH_W-1:0];
      else if (reg_hit(bus_req, OFS_DATA_LOW))
        nv_data_low <= bus_req.wdata;
      else if (reg_hit(bus_req, OFS_DATA_HIGH))
        nv_data_high <= bus_req.wdata[DATA_HIGH_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control register: triggers are set-only, cleared by hardware
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl <= '0;
    end
    else
    begin
      if (wr_ctrl)
      begin
        ctrl.space_select    <= bus_req.wdata[CTL_SPACE_BIT];
        ctrl.latch_only_load <= bus_req.wdata[CTL_LATCH_BIT];
        ctrl.commit_permit   <= bus_req.wdata[CTL_PERMIT_BIT];
      end
      if (write_accept)
        ctrl.wr_trig <= 1'b1;
      else if (end_write)
        ctrl.wr_trig <= 1'b0;
      if (read_accept)
        ctrl.rd_trig <= 1'b1;
      else if (ctrl.rd_trig)
        ctrl.rd_trig <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Unlock key tracker: any other write breaks the sequence
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      unlock_step <= 2'h0;
    else if (bus_req.wr)
    begin
      if (reg_hit(bus_req, OFS_UNLOCK) && bus_req.wdata == UNLOCK_KEY_FIRST)
        unlock_step <= 2'h1;
      else if (reg_hit(bus_req, OFS_UNLOCK) && bus_req.wdata == UNLOCK_KEY_LAST
               && unlock_step == 2'h1)
        unlock_step <= 2'h2;
      else
        unlock_step <= 2'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write sequencer
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state       <= ST_IDLE;
      timer       <= '0;
      setup_count <= 2'h0;
      commit_idx  <= '0;
      set_done    <= 1'b0;
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          setup_count <= 2'h0;
          if (write_accept)
            state <= ST_SETUP;
        end
        ST_SETUP:
        begin
          setup_count <= setup_count + 2'h1;
          timer       <= '0;
          commit_idx  <= '0;
          if (start_write)
          begin
            if (!ctrl.space_select)
            begin
              state    <= ST_PROGRAM;
              set_done <= 1'b1;
            end
            else if (pm_locked)
            begin
              state    <= ST_FINISH;
              set_done <= 1'b0;
            end
            else if (ctrl.latch_only_load)
            begin
              state    <= ST_FINISH;
              set_done <= 1'b0;
            end
            else
            begin
              state    <= ST_PROGRAM;
              set_done <= 1'b1;
            end
          end
        end
        ST_PROGRAM:
        begin
          timer <= timer + TIMER_W'(1);
          if (timer_done)
            state <= ctrl.space_select ? ST_COMMIT : ST_FINISH;
        end
        ST_COMMIT:
        begin
          commit_idx <= commit_idx + LATCH_IDX_W'(1);
          if (commit_idx == LATCH_IDX_W'(LATCH_WORDS - 1))
            state <= ST_FINISH;
        end
        ST_FINISH:
        begin
          state <= ST_IDLE;
        end
        default:
        begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Processor halt: only while the cells are being programmed
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      cpu_halt <= 1'b0;
    else if (start_write && !(ctrl.space_select && (pm_locked || ctrl.latch_only_load)))
      cpu_halt <= 1'b1;
    else if (state == ST_COMMIT && commit_idx == LATCH_IDX_W'(LATCH_WORDS - 1))
      cpu_halt <= 1'b0;
    else if (state == ST_PROGRAM && timer_done && !ctrl.space_select)
      cpu_halt <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Program memory write latches
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      latch_valid <= '0;
    else if (start_write && ctrl.space_select && !pm_locked)
      latch_valid[latch_idx] <= 1'b1;
    else if (state == ST_COMMIT)
      latch_valid[commit_idx] <= 1'b0;
  end

  generate
    for (genvar gi = 0; gi < LATCH_WORDS; gi++)
    begin : g_latch
      always_ff @(posedge clock)
      begin
        if (start_write && ctrl.space_select && !pm_locked
            && latch_idx == LATCH_IDX_W'(gi))
          latch_word[gi] <= pm_wdata;
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Array updates: EEPROM erased at start, programmed at timer expiry
  always_ff @(posedge clock)
  begin
    if (start_write && !ctrl.space_select)
      ee_mem[nv_addr_low] <= ERASED_BYTE;
    else if (state == ST_PROGRAM && timer_done && !ctrl.space_select)
      ee_mem[nv_addr_low] <= nv_data_low;
  end

  always_ff @(posedge clock)
  begin
    if (state == ST_COMMIT && latch_valid[commit_idx])
      pm_mem[{pm_addr[PM_ADDR_W-1:LATCH_IDX_W], commit_idx}] <= latch_word[commit_idx];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Done flag: set wins over a software clear
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      nv_done_flag <= 1'b0;
    else if (end_write && set_done)
      nv_done_flag <= 1'b1;
    else if (bus_req.wr && reg_hit(bus_req, OFS_FLAGS2) && !bus_req.wdata[FLG_DONE_BIT])
      nv_done_flag <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power-on domain: watches the device reset to catch an interrupted write
  always_ff @(posedge clock or negedge por_n)
  begin
    if (!por_n)
      rst_sample <= 3'h0;
    else
      rst_sample <= {rst_sample[1:0], rst_n};
  end

  always_ff @(posedge clock or negedge por_n)
  begin
    if (!por_n)
    begin
      busy_por          <= 1'b0;
      commit_abort_flag <= 1'b0;
    end
    else if (!rst_sample[1] && !rst_sample[2])
    begin
      busy_por <= 1'b0;
      if (busy_por)
        commit_abort_flag <= 1'b1;
    end
    else
    begin
      if (start_write)
        busy_por <= 1'b1;
      else if (end_write)
        busy_por <= 1'b0;
      if (wr_ctrl && !bus_req.wdata[CTL_ABORT_BIT])
        commit_abort_flag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Code protection only gates the external programmer port
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      programmer_deny <= 1'b1;
    else
      programmer_deny <= code_protect;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the read strobe
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      rdata <= RESET_BYTE;
    else if (bus_req.rd)
    begin
      if (reg_hit(bus_req, OFS_ADDR_LOW))
        rdata <= nv_addr_low;
      else if (reg_hit(bus_req, OFS_ADDR_HIGH))
        rdata <= {1'b0, nv_addr_high};
      else if (reg_hit(bus_req, OFS_DATA_LOW))
        rdata <= nv_data_low;
      else if (reg_hit(bus_req, OFS_DATA_HIGH))
        rdata <= {2'b00, nv_data_high};
      else if (reg_hit(bus_req, OFS_CONTROL))
        rdata <= {ctrl.space_select, 1'b0, ctrl.latch_only_load, 1'b0,
                  commit_abort_flag, ctrl.commit_permit, ctrl.wr_trig, ctrl.rd_trig};
      else if (reg_hit(bus_req, OFS_FLAGS2))
        rdata <= {3'b000, nv_done_flag, 4'h0};
      else
        rdata <= RESET_BYTE;
    end
    else
      rdata <= RESET_BYTE;
  end

endmodule // nvc_access_ctrl

// >>> testbench/nvc_access_assertions.sv
// Port checker of the nonvolatile access controller.
// Bound from the bench top; sees only the controller's ports.
`timescale 1ns/1ns
module nvc_access_assertions
  import nvc_pkg::*;
#(
  parameter int WRITE_CYCLES = 20
)
(
  input wire logic                     clock,
  input wire logic                     rst_n,
  input wire logic                     por_n,
  input wire nvc_pkg::nvc_bus_req_type bus_req,
  input wire logic [7:0]               rdata,
  input wire logic [1:0]               self_program_lock,
  input wire logic                     code_protect,
  input wire logic                     cpu_halt,
  input wire logic                     programmer_deny
);
  logic       ctl_trig;
  logic       quiet;
  logic [3:0] trig_hist;
  logic [9:0] halt_len;

  assign ctl_trig = bus_req.wr && bus_req.addr == OFS_CONTROL && bus_req.wdata[CTL_WR_BIT];
  assign quiet    = trig_hist == 4'h0 && !cpu_halt;

  ////////////////////////////////////////////////////////////////////////////
  // Recent triggers and length of the current halt
  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n)
      trig_hist <= 4'h0;
    else
      trig_hist <= {trig_hist[2:0], ctl_trig};

  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n)
      halt_len <= 10'h000;
    else if (!cpu_halt)
      halt_len <= 10'h000;
    else
      halt_len <= halt_len + 10'h001;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_unlock_zero: assert property (
    bus_req.rd && bus_req.addr == OFS_UNLOCK |=> rdata == 8'h00)
    else $error("unlock register read not zero");
  a_deny_follows: assert property (
    $past(rst_n) |-> programmer_deny == $past(code_protect))
    else $error("programmer deny does not follow protection");
  a_halt_cause: assert property (
    $rose(cpu_halt) |-> $past(ctl_trig, 3) || $past(ctl_trig, 4))
    else $error("halt without write trigger three cycles before");
  a_halt_length: assert property (
    $fell(cpu_halt) |-> halt_len >= WRITE_CYCLES - 1)
    else $error("halt shorter than write time");
  a_halt_bounded: assert property (
    halt_len <= WRITE_CYCLES + 40)
    else $error("halt lasts too long");
  a_reset_quiet: assert property (disable iff (1'b0)
    !rst_n |-> !cpu_halt && programmer_deny && rdata == 8'h00)
    else $error("outputs not quiet in reset");
  a_no_permit_stall: assert property (
    ctl_trig && !bus_req.wdata[CTL_PERMIT_BIT] && quiet |=> !cpu_halt [*6])
    else $error("write ran without permit");
  a_latch_no_stall: assert property (
    ctl_trig && bus_req.wdata[CTL_LATCH_BIT] && bus_req.wdata[CTL_SPACE_BIT] && quiet
    |=> !cpu_halt [*6])
    else $error("latch load stalled the processor");

  c_halt_rise: cover property ($rose(cpu_halt));
  c_halt_fall: cover property ($fell(cpu_halt));
  c_latch_load: cover property (ctl_trig && bus_req.wdata[CTL_LATCH_BIT]);
endmodule // nvc_access_assertions

// >>> testbench/nvc_access_ctrl_tb_top.sv
// Self-checking bench of the access controller over its register port.
// Assumes the package and controller are compiled first; binds the checker.
`timescale 1ns/1ns
module nvc_access_ctrl_tb_top;
  import nvc_pkg::*;
  localparam int WRITE_CYCLES = 20;
  logic            clock;
  logic            rst_n;
  logic            por_n;
  nvc_bus_req_type bus_req;
  logic [7:0]      rdata;
  logic [1:0]      self_program_lock;
  logic            code_protect;
  logic            cpu_halt;
  logic            programmer_deny;
  int              n_mismatch;
  int              checks_done;
  int              cycles;

  nvc_access_ctrl #(.WRITE_CYCLES(WRITE_CYCLES)) i_nvc_access_ctrl (
    .clock(clock), .rst_n(rst_n), .por_n(por_n), .bus_req(bus_req), .rdata(rdata),
    .self_program_lock(self_program_lock), .code_protect(code_protect),
    .cpu_halt(cpu_halt), .programmer_deny(programmer_deny));

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      n_mismatch = n_mismatch + 1;
      wrap_up();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("Mismatches %0d, checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done = checks_done + 1;
    if (seen !== exp)
    begin
      n_mismatch = n_mismatch + 1;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clock);
  endtask

  task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    bus_req <= '0;
  endtask

  // Read data stand only in the cycle after the read edge
  task automatic bus_rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clock);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    bus_req <= '0;
    #1 check(rdata, exp);
  endtask

  task automatic unlock_write(input logic [7:0] ctl);
    bus_wr(OFS_UNLOCK, UNLOCK_KEY_FIRST);
    bus_wr(OFS_UNLOCK, UNLOCK_KEY_LAST);
    bus_wr(OFS_CONTROL, ctl);
  endtask

  task automatic wait_halt(input logic lvl);
    int n;
    n = 0;
    while (cpu_halt !== lvl && n < 300)
    begin
      @(posedge clock);
      #1 n = n + 1;
    end
    check({7'h00, cpu_halt}, {7'h00, lvl});
  endtask

  task automatic ee_write(input logic [7:0] d);
    bus_wr(OFS_DATA_LOW, d);
    unlock_write(8'h06);
    wait_halt(1'b1);
    wait_halt(1'b0);
    idle(2);
  endtask

  task automatic ee_read(input logic [7:0] exp);
    bus_wr(OFS_DATA_LOW, 8'h00);
    bus_wr(OFS_CONTROL, 8'h05);
    idle(3);
    bus_rd(OFS_DATA_LOW, exp);
  endtask

  task automatic pm_read(input logic [7:0] hi, input logic [7:0] lo);
    bus_wr(OFS_ADDR_HIGH, 8'h12);
    bus_wr(OFS_ADDR_LOW, 8'h34);
    bus_wr(OFS_DATA_LOW, 8'h00);
    bus_wr(OFS_DATA_HIGH, 8'h00);
    bus_wr(OFS_CONTROL, 8'h81);
    idle(3);
    bus_rd(OFS_DATA_HIGH, hi);
    bus_rd(OFS_DATA_LOW, lo);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    bus_rd(OFS_CONTROL, 8'h00);
    bus_wr(OFS_UNLOCK, UNLOCK_KEY_FIRST);
    bus_rd(OFS_UNLOCK, 8'h00);
    check({7'h00, programmer_deny}, 8'h00);
  endtask

  // Overwrite of the top byte checks the second value is read back
  task automatic t_ee();
    @(posedge clock);
    code_protect <= 1'b1;
    bus_wr(OFS_ADDR_LOW, 8'hff);
    bus_wr(OFS_CONTROL, 8'h04);
    ee_write(8'h3c);
    ee_write(8'hc3);
    bus_rd(OFS_CONTROL, 8'h04);
    bus_rd(OFS_FLAGS2, 8'h10);
    check({7'h00, programmer_deny}, 8'h01);
    ee_read(8'hc3);
    bus_rd(OFS_CONTROL, 8'h04);
    bus_wr(OFS_FLAGS2, 8'h00);
    bus_rd(OFS_FLAGS2, 8'h00);
  endtask

  task automatic t_no_key();
    bus_wr(OFS_DATA_LOW, 8'h99);
    bus_wr(OFS_UNLOCK, UNLOCK_KEY_FIRST);
    bus_wr(OFS_ADDR_LOW, 8'hff);
    bus_wr(OFS_UNLOCK, UNLOCK_KEY_LAST);
    bus_wr(OFS_CONTROL, 8'h06);
    idle(8);
    check({7'h00, cpu_halt}, 8'h00);
    bus_wr(OFS_CONTROL, 8'h00);
    unlock_write(8'h02);
    idle(8);
    check({7'h00, cpu_halt}, 8'h00);
    ee_read(8'hc3);
  endtask

  task automatic t_pm();
    bus_wr(OFS_ADDR_HIGH, 8'h12);
    bus_wr(OFS_ADDR_LOW, 8'h34);
    bus_wr(OFS_DATA_HIGH, 8'h2a);
    bus_wr(OFS_DATA_LOW, 8'h5c);
    bus_wr(OFS_CONTROL, 8'h84);
    unlock_write(8'h86);
    wait_halt(1'b1);
    wait_halt(1'b0);
    idle(4);
    pm_read(8'h2a, 8'h5c);
    bus_wr(OFS_CONTROL, 8'ha4);
    unlock_write(8'ha6);
    idle(8);
    check({7'h00, cpu_halt}, 8'h00);
    bus_rd(OFS_CONTROL, 8'ha4);
    @(posedge clock);
    self_program_lock <= LOCK_HALF;
    bus_wr(OFS_ADDR_HIGH, 8'h01);
    bus_wr(OFS_ADDR_LOW, 8'h00);
    bus_wr(OFS_CONTROL, 8'h84);
    unlock_write(8'h86);
    idle(8);
    check({7'h00, cpu_halt}, 8'h00);
    // Every block locked: a write to the known word must leave it alone
    @(posedge clock);
    self_program_lock <= 2'h0;
    bus_wr(OFS_ADDR_HIGH, 8'h12);
    bus_wr(OFS_ADDR_LOW, 8'h34);
    bus_wr(OFS_DATA_HIGH, 8'h11);
    bus_wr(OFS_DATA_LOW, 8'h22);
    bus_wr(OFS_CONTROL, 8'h84);
    unlock_write(8'h86);
    idle(8);
    check({7'h00, cpu_halt}, 8'h00);
    pm_read(8'h2a, 8'h5c);
  endtask

  // Device reset in mid-write leaves the abort flag set
  task automatic t_abort();
    @(posedge clock);
    self_program_lock <= LOCK_NONE;
    bus_wr(OFS_CONTROL, 8'h04);
    bus_wr(OFS_ADDR_LOW, 8'h10);
    ee_write(8'h77);
    bus_wr(OFS_DATA_LOW, 8'h11);
    unlock_write(8'h06);
    wait_halt(1'b1);
    idle(3);
    rst_n <= 1'b0;
    idle(4);
    rst_n <= 1'b1;
    bus_rd(OFS_CONTROL, 8'h08);
    bus_wr(OFS_CONTROL, 8'h00);
    bus_rd(OFS_CONTROL, 8'h00);
    // The cut write had erased the byte but never programmed it
    bus_wr(OFS_ADDR_LOW, 8'h10);
    ee_read(8'hff);
  endtask

  initial
  begin
    n_mismatch = 0;
    checks_done = 0;
    cycles = 0;
    rst_n = 1'b1;
    por_n = 1'b1;
    bus_req = '0;
    self_program_lock = LOCK_NONE;
    code_protect = 1'b0;
    // A clean falling edge after time zero so the async resets fire before the first clock
    #1;
    rst_n = 1'b0;
    por_n = 1'b0;
    idle(4);
    rst_n <= 1'b1;
    por_n <= 1'b1;
    t_reset();
    t_ee();
    t_no_key();
    t_pm();
    t_abort();
    wrap_up();
  end
endmodule // nvc_access_ctrl_tb_top

bind nvc_access_ctrl nvc_access_assertions #(.WRITE_CYCLES(WRITE_CYCLES)) i_nvc_access_assertions (
  .clock(clock), .rst_n(rst_n), .por_n(por_n), .bus_req(bus_req), .rdata(rdata),
  .self_program_lock(self_program_lock), .code_protect(code_protect),
  .cpu_halt(cpu_halt), .programmer_deny(programmer_deny));
